/* logic/vfd_regs.svh */
// Encoding, field positions and reset constants of the fetch and dispatch unit
`ifndef VFD_REGS_SVH
`define VFD_REGS_SVH
`define VFD_SLOTS      8
`define VFD_FP_BITS    256
`define VFD_FP_BYTES   32'h00000020
`define VFD_FP_MASK    32'hFFFFFFE0
`define VFD_RESET_PC   32'h00000000
`define VFD_NREGS      16
`define VFD_RAW        4
`define VFD_NRD        13
`define VFD_NWR        7
`define VFD_XRD_PORT   8
`define VFD_CREG_PORT  9
`define VFD_CHAIN      0
`define VFD_UNIT_LSB   1
`define VFD_COND_LSB   4
`define VFD_CZ         7
`define VFD_DST_LSB    8
`define VFD_S1_LSB     12
`define VFD_S2_LSB     16
`define VFD_X          20
`define VFD_OPC_LSB    21
`define VFD_S_OFF_LSB  25
`define VFD_D_LONG     16
`define VFD_D_ST       17
`define VFD_D_SZ_LSB   18
`define VFD_D_DX       20
`define VFD_D_CIRC     21
`define VFD_D_OFF_LSB  22
`define VFD_D_LOFF_LSB 17
`define VFD_OP_ADD     4'h0
`define VFD_OP_SUB     4'h1
`define VFD_OP_AND     4'h2
`define VFD_OP_OR      4'h3
`define VFD_OP_XOR     4'h4
`define VFD_OP_LBR     4'h6
`define VFD_OP_FABS    4'h8
`define VFD_OP_FNEG    4'h9
`define VFD_OP_SHL     4'h1
`define VFD_OP_SHR     4'h2
`define VFD_OP_SRA     4'h3
`define VFD_OP_SBR     4'h4
`define VFD_OP_LOAD_DW 4'h5
`define VFD_OP_MPY     4'h0
`define VFD_OP_MPYU    4'h1
`define VFD_OP_FMPY    4'h8
`define VFD_SZ_BYTE    2'h0
`define VFD_SZ_HALF    2'h1
`define VFD_SZ_WORD    2'h2
`define VFD_SZ_DWORD   2'h3
`define VFD_FBIAS      10'h07F
`endif

/* logic/vfd_pkg.sv */
// Types shared by the fetch and dispatch unit
package vfd_pkg;
	typedef enum logic [1:0] {cls_logic, cls_shift, cls_mult, cls_data} vfd_class_type;
	typedef struct packed {
		logic        valid;
		logic        store;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [7:0]  be;
		logic [63:0] wdata;
	} vfd_memreq_type;
	typedef struct packed {
		logic        valid;
		logic [3:0]  opc;
		logic [31:0] result;
	} vfd_issue_type;
	typedef struct packed {
		logic       side;
		logic [3:0] dreg;
		logic [1:0] size;
		logic [2:0] lo;
	} vfd_ldtag_type;
endpackage

/* logic/vfd_side_regs.sv */
// One side's sixteen-entry register file with many read and write ports
`timescale 1ns/1ps
`include "vfd_regs.svh"
module vfd_side_regs import vfd_pkg::*; #(
	parameter int WIDTH = 32,
	parameter int DEPTH = `VFD_NREGS,
	parameter int NR    = `VFD_NRD,
	parameter int NW    = `VFD_NWR,
	parameter int AW    = $clog2(DEPTH)
) (
	// Clock and reset
	input  wire logic                      ref_clk_i,
	input  wire logic                      rst_i,
	// Read ports
	input  wire logic [NR-1:0][AW-1:0]     rd_addr_i,
	output logic [NR-1:0][WIDTH-1:0]       rd_data_o,
	// Write ports, higher index wins
	input  wire logic [NW-1:0]             wr_en_i,
	input  wire logic [NW-1:0][AW-1:0]     wr_addr_i,
	input  wire logic [NW-1:0][WIDTH-1:0]  wr_data_i
);
	logic [WIDTH-1:0] mem_r [DEPTH];

	// Sixteen words, all ports in one cycle [RL10] [RL11]
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else begin
			for (int p = 0; p < NW; p++) begin
				if (wr_en_i[p]) begin
					mem_r[wr_addr_i[p]] <= wr_data_i[p];
				end
			end
		end
	end

	always_comb begin
		for (int r = 0; r < NR; r++) begin
			rd_data_o[r] = mem_r[rd_addr_i[r]];
		end
	end
endmodule

/* logic/vfd_fetch_dispatch.sv */
// Fetch and dispatch front end with two register sides and eight units
`timescale 1ns/1ps
`include "vfd_regs.svh"
// Summary of operation
// RL1: Fetch whole 256-bit packets of eight slots
// RL2: Low bit one chains next instruction
// RL3: Low bit zero ends the execute packet
// RL4: Packets hold one to eight instructions
// RL5: One to eight packets per fetch
// RL6: One packet per clock, routed by unit
// RL7: No new fetch until packet drained
// RL8: Units without instruction stay idle
// RL9: Two sides, four units each
// RL10: Sixteen 32-bit registers per side
// RL11: Own side serves all units per cycle
// RL12: One cross read, one cross write
// RL13: Float ops on logic, multiply, data units; the data units here do no float ops and only pass operand a
// RL14: Shift units do double-word loads
// RL15: Only data path moves memory data
// RL16: Linear or circular, 5 or 15-bit offsets
// RL17: Every instruction conditional on a register
// RL18: Multiply units only multiply
// RL19: Logic and shift do arithmetic, branches
// RL20: Byte, half-word and word memory access
// RL21: Packets never cross; trailing NOPs skipped
module vfd_fetch_dispatch import vfd_pkg::*; #(
	parameter int CIRC_LOG2 = 8
) (
	// Clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              rst_i,
	// Program fetch
	output logic                   fetch_req_o,
	output logic [31:0]            fetch_addr_o,
	input  wire logic              fetch_ack_i,
	input  wire logic [255:0]      fetch_data_i,
	// Data memory, one port per side
	output vfd_memreq_type [1:0]   dmem_req_o,
	input  wire logic [1:0]        dmem_rvalid_i,
	input  wire logic [1:0][63:0]  dmem_rdata_i,
	// Issue status
	output vfd_issue_type [7:0]    unit_issue_o,
	output logic                   pkt_issue_o,
	output logic                   conflict_o
);
	typedef enum logic [0:0] {st_fetch, st_dispatch} vfd_state_type;

	vfd_state_type                  state_r;
	logic [31:0]                    pc_r;
	logic [255:0]                   pkt_r;
	logic [2:0]                     ptr_r;
	logic [1:0]                     pend_r;
	vfd_ldtag_type [1:0]            tag_r;
	vfd_ldtag_type [1:0]            tag_nxt;
	vfd_issue_type [7:0]            issue_r;
	vfd_memreq_type [1:0]           mreq_r;
	vfd_memreq_type [1:0]           mreq_nxt;
	logic                           pkt_issue_r;
	logic                           conflict_r;
	logic [7:0]                     in_pkt;
	logic [2:0]                     last_slot;
	logic [31:0]                    last_word;
	logic                           pkt_done;
	logic                           go;
	logic                           dup;
	logic                           br_take;
	logic [31:0]                    br_tgt;
	logic [7:0]                     hit;
	logic [7:0]                     exe;
	logic [7:0]                     xgr;
	logic [7:0]                     issue_valid;
	logic [7:0][31:0]               ins;
	logic [7:0][31:0]               opa;
	logic [7:0][31:0]               opb;
	logic [7:0][31:0]               res;
	logic [1:0][12:0][3:0]          rd_addr;
	logic [1:0][12:0][31:0]         rd_data;
	logic [1:0][6:0]                wr_en;
	logic [1:0][6:0][3:0]           wr_addr;
	logic [1:0][6:0][31:0]          wr_data;

	function automatic logic [31:0] slot(input logic [255:0] p, input logic [2:0] i);
		return p[i*32 +: 32];
	endfunction

	function automatic logic is_nop(input logic [31:0] w);
		return (w[`VFD_COND_LSB +: 3] == 3'h0) && w[`VFD_CZ];
	endfunction

	function automatic logic [31:0] fmul(input logic [31:0] a, input logic [31:0] b);
		logic [47:0] m;
		logic [9:0]  e;
		m = 48'({1'b1, a[22:0]}) * 48'({1'b1, b[22:0]});
		e = {2'h0, a[30:23]} + {2'h0, b[30:23]} - `VFD_FBIAS + {9'h000, m[47]};
		if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e[9]) begin
			return {a[31] ^ b[31], 31'h00000000};
		end else if (e[8] || e[7:0] == 8'hFF) begin
			return {a[31] ^ b[31], 8'hFF, 23'h000000};
		end
		return {a[31] ^ b[31], e[7:0], m[47] ? m[46:24] : m[45:23]};
	endfunction

	function automatic logic [31:0] alu(input vfd_class_type c, input logic [3:0] op,
		input logic [31:0] a, input logic [31:0] b);
		logic [31:0] r;
		r = a + b;
		unique case (c)
			cls_logic: begin
				case (op) // [RL19] [RL13]
					`VFD_OP_SUB:  r = a - b;
					`VFD_OP_AND:  r = a & b;
					`VFD_OP_OR:   r = a | b;
					`VFD_OP_XOR:  r = a ^ b;
					`VFD_OP_FABS: r = {1'b0, a[30:0]};
					`VFD_OP_FNEG: r = {~a[31], a[30:0]};
					default:      r = a + b;
				endcase
			end
			cls_shift: begin
				case (op) // [RL19]
					`VFD_OP_SHL: r = a << b[4:0];
					`VFD_OP_SHR: r = a >> b[4:0];
					`VFD_OP_SRA: r = $unsigned($signed(a) >>> b[4:0]);
					default:     r = a + b;
				endcase
			end
			cls_mult: begin
				case (op) // [RL18] [RL13]
					`VFD_OP_MPYU: r = {16'h0000, a[15:0]} * {16'h0000, b[15:0]};
					`VFD_OP_FMPY: r = fmul(a, b);
					default:      r = {{16{a[15]}}, a[15:0]} * {{16{b[15]}}, b[15:0]};
				endcase
			end
			cls_data: r = a;
		endcase
		return r;
	endfunction

	function automatic logic [7:0] mem_be(input logic [1:0] sz, input logic [2:0] lo);
		case (sz) // [RL20]
			`VFD_SZ_BYTE: return 8'h01 << lo;
			`VFD_SZ_HALF: return 8'h03 << {lo[2:1], 1'b0};
			`VFD_SZ_WORD: return 8'h0F << {lo[2], 2'h0};
			default:      return 8'hFF;
		endcase
	endfunction

	function automatic logic [31:0] ld_val(input logic [63:0] d, input logic [1:0] sz,
		input logic [2:0] lo);
		logic [63:0] sh;
		sh = d >> {lo, 3'h0};
		case (sz) // [RL20]
			`VFD_SZ_BYTE: return {{24{sh[7]}}, sh[7:0]};
			`VFD_SZ_HALF: return {{16{sh[15]}}, sh[15:0]};
			default:      return sh[31:0];
		endcase
	endfunction

	assign go = (state_r == st_dispatch) && (pend_r == 2'h0);
	assign last_word = slot(pkt_r, last_slot);

	// Chain walk and routing of one execute packet
	always_comb begin
		logic        run;
		logic [31:0] w;
		run = 1'b1;
		w = '0;
		in_pkt = 8'h00;
		last_slot = ptr_r;
		hit = 8'h00;
		ins = '0;
		dup = 1'b0;
		pkt_done = 1'b1;
		for (int i = 0; i < `VFD_SLOTS; i++) begin
			w = slot(pkt_r, 3'(i));
			if (3'(i) >= ptr_r && run) begin
				in_pkt[i] = 1'b1; // [RL4] [RL5]
				last_slot = 3'(i);
				run = w[`VFD_CHAIN]; // [RL2] [RL3]
				if (!is_nop(w)) begin
					if (hit[w[`VFD_UNIT_LSB +: 3]]) begin
						dup = 1'b1;
					end else begin
						hit[w[`VFD_UNIT_LSB +: 3]] = 1'b1; // [RL6]
						ins[w[`VFD_UNIT_LSB +: 3]] = w;
					end
				end
			end
		end
		for (int j = 0; j < `VFD_SLOTS; j++) begin
			if (3'(j) > last_slot && !is_nop(slot(pkt_r, 3'(j)))) begin
				pkt_done = 1'b0; // [RL21]
			end
		end
	end

	// Register read addresses and cross-path grant
	always_comb begin
		logic [1:0] gx;
		gx = 2'h0;
		xgr = 8'h00;
		rd_addr = '0;
		for (int u = 0; u < 8; u++) begin
			logic xr;
			xr = (u % 4 == 3) ? (!ins[u][`VFD_D_LONG] && ins[u][`VFD_D_DX]) : ins[u][`VFD_X];
			rd_addr[u / 4][2 * (u % 4)] = ins[u][`VFD_S1_LSB +: 4];
			rd_addr[u / 4][2 * (u % 4) + 1] = (u % 4 == 3) ? ins[u][`VFD_DST_LSB +: 4]
				: ins[u][`VFD_S2_LSB +: 4];
			if (hit[u] && xr && !gx[u / 4]) begin
				gx[u / 4] = 1'b1; // [RL12]
				xgr[u] = 1'b1;
				rd_addr[1 - u / 4][`VFD_XRD_PORT] = rd_addr[u / 4][2 * (u % 4) + 1];
			end
		end
		for (int s = 0; s < 2; s++) begin
			for (int k = 0; k < 4; k++) begin
				rd_addr[s][`VFD_CREG_PORT + k] = 4'(k);
			end
		end
	end

	// Condition test, execution, write-back and memory requests
	always_comb begin
		logic [2:0]  sel;
		logic [31:0] cval;
		logic [31:0] off;
		logic [31:0] sum;
		logic [31:0] msk;
		logic [3:0]  op;
		logic        s;
		sel = '0;
		cval = '0;
		off = '0;
		sum = '0;
		op = '0;
		s = 1'b0;
		msk = ~(32'hFFFFFFFF << CIRC_LOG2);
		exe = 8'h00;
		br_take = 1'b0;
		br_tgt = '0;
		wr_en = '0;
		wr_addr = '0;
		wr_data = '0;
		mreq_nxt = '0;
		tag_nxt = '0;
		for (int u = 0; u < 8; u++) begin
			sel = ins[u][`VFD_COND_LSB +: 3];
			op = ins[u][`VFD_OPC_LSB +: 4];
			cval = rd_data[sel[2]][`VFD_CREG_PORT + sel[1:0]];
			opa[u] = rd_data[u / 4][2 * (u % 4)];
			opb[u] = xgr[u] ? rd_data[1 - u / 4][`VFD_XRD_PORT] : rd_data[u / 4][2 * (u % 4) + 1];
			res[u] = alu(vfd_class_type'(u % 4), op, opa[u], opb[u]);
			exe[u] = go && hit[u] && ((sel == 3'h0) || (ins[u][`VFD_CZ] ? (cval == 32'h0)
				: (cval != 32'h0))); // [RL17] [RL8]
			if (exe[u] && ((u % 4 == 0 && op == `VFD_OP_LBR) || (u % 4 == 1 && op == `VFD_OP_SBR))) begin
				br_take = 1'b1; // [RL19]
				br_tgt = opa[u];
			end
			wr_en[u / 4][u % 4] = exe[u] && (u % 4 != 3) && !(u % 4 == 0 && op == `VFD_OP_LBR)
				&& !(u % 4 == 1 && (op == `VFD_OP_SBR || op == `VFD_OP_LOAD_DW)); // [RL11]
			wr_addr[u / 4][u % 4] = ins[u][`VFD_DST_LSB +: 4];
			wr_data[u / 4][u % 4] = res[u];
		end
		for (int t = 0; t < 2; t++) begin
			s = t[0];
			if (exe[4 * t + 3]) begin
				if (ins[4 * t + 3][`VFD_D_LONG]) begin
					off = {15'h0000, ins[4 * t + 3][`VFD_D_LOFF_LSB +: 15], 2'h0}; // [RL16]
					mreq_nxt[t].size = `VFD_SZ_WORD;
				end else begin
					mreq_nxt[t].size = ins[4 * t + 3][`VFD_D_SZ_LSB +: 2];
					mreq_nxt[t].store = ins[4 * t + 3][`VFD_D_ST];
					off = {27'h0000000, ins[4 * t + 3][`VFD_D_OFF_LSB +: 5]} << mreq_nxt[t].size;
				end
				sum = opa[4 * t + 3] + off;
				mreq_nxt[t].addr = (ins[4 * t + 3][`VFD_D_CIRC] && !ins[4 * t + 3][`VFD_D_LONG])
					? ((opa[4 * t + 3] & ~msk) | (sum & msk)) : sum; // [RL16]
				mreq_nxt[t].valid = 1'b1; // [RL15]
				mreq_nxt[t].wdata = (mreq_nxt[t].size == `VFD_SZ_BYTE) ? {8{opb[4 * t + 3][7:0]}}
					: (mreq_nxt[t].size == `VFD_SZ_HALF) ? {4{opb[4 * t + 3][15:0]}}
					: {2{opb[4 * t + 3]}}; // [RL20]
				tag_nxt[t].side = (!ins[4 * t + 3][`VFD_D_LONG] && ins[4 * t + 3][`VFD_D_DX]) ? ~s : s;
				tag_nxt[t].dreg = ins[4 * t + 3][`VFD_DST_LSB +: 4];
			end else if (exe[4 * t + 1] && ins[4 * t + 1][`VFD_OPC_LSB +: 4] == `VFD_OP_LOAD_DW) begin
				mreq_nxt[t].valid = 1'b1; // [RL14] [RL15]
				mreq_nxt[t].size = `VFD_SZ_DWORD;
				mreq_nxt[t].addr = opa[4 * t + 1]
					+ {24'h000000, ins[4 * t + 1][`VFD_S_OFF_LSB +: 5], 3'h0};
				tag_nxt[t].side = s;
				tag_nxt[t].dreg = ins[4 * t + 1][`VFD_DST_LSB +: 4];
			end
			mreq_nxt[t].be = mem_be(mreq_nxt[t].size, mreq_nxt[t].addr[2:0]);
			tag_nxt[t].size = mreq_nxt[t].size;
			tag_nxt[t].lo = mreq_nxt[t].addr[2:0];
			// Load return: own side on ports 4 and 5, other side on cross port 6
			if (dmem_rvalid_i[t] && pend_r[t]) begin
				if (tag_r[t].side == s) begin
					wr_en[t][4] = 1'b1;
					wr_addr[t][4] = tag_r[t].dreg;
					wr_data[t][4] = ld_val(dmem_rdata_i[t], tag_r[t].size, tag_r[t].lo);
					wr_en[t][5] = (tag_r[t].size == `VFD_SZ_DWORD); // [RL14]
					wr_addr[t][5] = tag_r[t].dreg + 4'h1;
					wr_data[t][5] = dmem_rdata_i[t][63:32];
				end else begin
					wr_en[1 - t][6] = 1'b1; // [RL12] [RL15]
					wr_addr[1 - t][6] = tag_r[t].dreg;
					wr_data[1 - t][6] = ld_val(dmem_rdata_i[t], tag_r[t].size, tag_r[t].lo);
				end
			end
		end
	end

	// Two sides of four units around their own register file [RL9]
	for (genvar g = 0; g < 2; g++) begin : g_side
		vfd_side_regs #(
			.WIDTH (32),
			.DEPTH (`VFD_NREGS),
			.NR    (`VFD_NRD),
			.NW    (`VFD_NWR)
		) u_regs (
			.ref_clk_i (ref_clk_i),
			.rst_i     (rst_i),
			.rd_addr_i (rd_addr[g]),
			.rd_data_o (rd_data[g]),
			.wr_en_i   (wr_en[g]),
			.wr_addr_i (wr_addr[g]),
			.wr_data_i (wr_data[g])
		);
	end

	// Fetch and packet sequencing
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= st_fetch;
			pc_r <= `VFD_RESET_PC;
			pkt_r <= '0;
			ptr_r <= 3'h0;
		end else if (state_r == st_fetch) begin
			if (fetch_ack_i) begin
				pkt_r <= fetch_data_i; // [RL1]
				ptr_r <= 3'h0;
				pc_r <= pc_r + `VFD_FP_BYTES;
				state_r <= st_dispatch;
			end
		end else if (go) begin
			if (br_take) begin
				pc_r <= br_tgt & `VFD_FP_MASK;
				state_r <= st_fetch;
			end else if (pkt_done) begin
				state_r <= st_fetch; // [RL7] [RL21]
			end else begin
				ptr_r <= last_slot + 3'h1; // [RL6]
			end
		end
	end

	// Issue status and memory request registers
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			issue_r <= '0;
			mreq_r <= '0;
			pkt_issue_r <= 1'b0;
			conflict_r <= 1'b0;
		end else begin
			for (int u = 0; u < 8; u++) begin
				issue_r[u].valid <= exe[u]; // [RL8]
				issue_r[u].opc <= ins[u][`VFD_OPC_LSB +: 4];
				issue_r[u].result <= (u % 4 == 3 || (u % 4 == 1
					&& ins[u][`VFD_OPC_LSB +: 4] == `VFD_OP_LOAD_DW)) ? mreq_nxt[u / 4].addr : res[u];
			end
			mreq_r <= mreq_nxt;
			pkt_issue_r <= go;
			conflict_r <= go && dup;
		end
	end

	// Outstanding load per side holds dispatch
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pend_r <= 2'h0;
			tag_r <= '0;
		end else begin
			for (int t = 0; t < 2; t++) begin
				if (mreq_nxt[t].valid && !mreq_nxt[t].store) begin
					pend_r[t] <= 1'b1; // [RL20]
					tag_r[t] <= tag_nxt[t];
				end else if (dmem_rvalid_i[t]) begin
					pend_r[t] <= 1'b0;
				end
			end
		end
	end

	assign fetch_req_o = (state_r == st_fetch);
	assign fetch_addr_o = pc_r;
	assign dmem_req_o = mreq_r;
	assign unit_issue_o = issue_r;
	assign pkt_issue_o = pkt_issue_r;
	assign conflict_o = conflict_r;

	always_comb begin
		for (int u = 0; u < 8; u++) begin
			issue_valid[u] = issue_r[u].valid;
		end
	end

	chk_fetch_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL1]
		fetch_req_o && !fetch_ack_i |=> fetch_req_o && $stable(fetch_addr_o))
		else $error("fetch request dropped before acknowledge");
	chk_fetch_wait: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL7]
		go && !pkt_done && !br_take |=> !fetch_req_o)
		else $error("fetch while packets remain");
	chk_chain_break: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL3]
		go |-> (last_slot == 3'h7) || !last_word[`VFD_CHAIN])
		else $error("execute packet ended on chained slot");
	chk_ptr_step: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL6]
		go && !pkt_done && !br_take |=> state_r == st_dispatch && ptr_r == $past(last_slot) + 3'h1)
		else $error("slot pointer did not advance by one packet");
	chk_idle_unit: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL8]
		!go |=> issue_valid == 8'h00 && !pkt_issue_o)
		else $error("unit issued without dispatch");
	chk_cross_one: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL12]
		$onehot0(xgr[3:0]) && $onehot0(xgr[7:4]))
		else $error("more than one cross read per side");
	chk_mem_source: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL15]
		dmem_req_o[0].valid |-> $past(exe[3] || exe[1]))
		else $error("memory request without data or load unit");
	chk_pkt_count: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL4]
		go |-> $countones(in_pkt) >= 1 && in_pkt[ptr_r])
		else $error("empty execute packet");
	chk_pad_skip: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL21]
		go && pkt_done |=> fetch_req_o ##0 fetch_addr_o[4:0] == 5'h00)
		else $error("padding not skipped to next fetch");
	chk_load_stall: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL20]
		pend_r != 2'h0 |=> issue_valid == 8'h00 && !pkt_issue_o && !dmem_req_o[0].valid
			&& !dmem_req_o[1].valid)
		else $error("dispatch during outstanding load");
endmodule

/* bench/vfd_mem_model.sv */
// Program and data memory model facing the fetch and dispatch unit
`timescale 1ns/1ps
module vfd_mem_model import vfd_pkg::*; (
	// Clock and reset
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_i,
	// Latency settings
	input  wire logic [3:0]            flat_i,
	input  wire logic [3:0]            dlat_i,
	// Program fetch
	input  wire logic                  fetch_req_i,
	input  wire logic [31:0]           fetch_addr_i,
	output logic                       fetch_ack_o,
	output logic [255:0]               fetch_data_o,
	// Data memory
	input  wire vfd_memreq_type [1:0]  dmem_req_i,
	output logic [1:0]                 dmem_rvalid_o,
	output logic [1:0][63:0]           dmem_rdata_o
);
	logic [255:0] prog [0:31];
	logic [3:0]   fcnt;
	logic [3:0]   dcnt [0:1];
	logic [1:0]   pend;
	logic [31:0]  da [0:1];
	logic         r;
	initial begin
		fetch_ack_o = 1'b0;
		fetch_data_o = '0;
		dmem_rvalid_o = 2'h0;
		dmem_rdata_o = '0;
		for (int i = 0; i < 32; i++) prog[i] = {8{32'h00000080}};
	end
	always @(posedge ref_clk_i) begin
		r = rst_i;
		#1;
		if (r) begin
			fetch_ack_o = 1'b0;
			dmem_rvalid_o = 2'h0;
			pend = 2'h0;
			fcnt = 4'h0;
		end else begin
			// Whole eight-slot packet per answer, scrambled when released
			if (fetch_ack_o) begin
				fetch_ack_o = 1'b0;
				fetch_data_o = ~fetch_data_o;
			end else if (fetch_req_i) begin
				if (fcnt >= flat_i) begin
					fetch_ack_o = 1'b1;
					fetch_data_o = prog[fetch_addr_i[9:5]];
					fcnt = 4'h0;
				end else fcnt++;
			end
			// Double-word answers for loads, one pending per side
			for (int s = 0; s < 2; s++) begin
				if (dmem_rvalid_o[s]) begin
					dmem_rvalid_o[s] = 1'b0;
					dmem_rdata_o[s] = ~dmem_rdata_o[s];
				end else if (pend[s]) begin
					if (dcnt[s] >= dlat_i) begin
						dmem_rvalid_o[s] = 1'b1;
						dmem_rdata_o[s] = {da[s] + 32'h00000303, da[s] + 32'h00000011};
						pend[s] = 1'b0;
					end else dcnt[s]++;
				end
				if (dmem_req_i[s].valid && !dmem_req_i[s].store) begin
					pend[s] = 1'b1;
					dcnt[s] = 4'h0;
					da[s] = {dmem_req_i[s].addr[31:3], 3'h0};
				end
			end
		end
	end
endmodule

/* bench/vliw_fetch_dispatch_unit_test.sv */
// Self-checking bench of the fetch and dispatch unit
`timescale 1ns/1ps
`include "vfd_regs.svh"
module vliw_fetch_dispatch_unit_test import vfd_pkg::*; ;
	typedef struct packed {vfd_issue_type [7:0] u; logic cf;} vfd_rec_type;
	logic                 ref_clk = 1'b0;
	logic                 rst = 1'b1;
	logic [3:0]           flat = 4'h0;
	logic [3:0]           dlat = 4'h0;
	logic                 fetch_req;
	logic [31:0]          fetch_addr;
	logic                 fetch_ack;
	logic [255:0]         fetch_data;
	vfd_memreq_type [1:0] dmem_req;
	logic [1:0]           rvalid;
	logic [1:0][63:0]     rdata;
	vfd_issue_type [7:0]  unit_issue;
	logic                 pkt_issue;
	logic                 conflict;
	int                   bad_count = 0;
	int                   checks = 0;
	int                   cyc = 0;
	int                   acks = 0;
	vfd_rec_type          rq [$];
	int                   kq [$];
	int                   cq [$];
	int                   fp [$];
	logic [31:0]          aq [$];
	logic [7:0]           eq [$];
	vfd_memreq_type       mq0 [$];
	vfd_memreq_type       mq1 [$];
	vfd_fetch_dispatch u_vfd_fetch_dispatch (.ref_clk_i(ref_clk), .rst_i(rst),
		.fetch_req_o(fetch_req), .fetch_addr_o(fetch_addr), .fetch_ack_i(fetch_ack),
		.fetch_data_i(fetch_data), .dmem_req_o(dmem_req), .dmem_rvalid_i(rvalid),
		.dmem_rdata_i(rdata), .unit_issue_o(unit_issue), .pkt_issue_o(pkt_issue),
		.conflict_o(conflict));
	vfd_mem_model u_vfd_mem_model (.ref_clk_i(ref_clk), .rst_i(rst), .flat_i(flat),
		.dlat_i(dlat), .fetch_req_i(fetch_req), .fetch_addr_i(fetch_addr),
		.fetch_ack_o(fetch_ack), .fetch_data_o(fetch_data), .dmem_req_i(dmem_req),
		.dmem_rvalid_o(rvalid), .dmem_rdata_o(rdata));
	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;
	// Issue, fetch and memory request log
	always @(negedge ref_clk) begin
		if (rst === 1'b0) begin
			if (pkt_issue === 1'b1) begin
				rq.push_back({unit_issue, conflict});
				kq.push_back(acks);
				cq.push_back(cyc);
			end
			if (fetch_req === 1'b1 && fetch_ack === 1'b1) begin
				acks++;
				aq.push_back(fetch_addr);
			end
			if (dmem_req[0].valid === 1'b1) mq0.push_back(dmem_req[0]);
			if (dmem_req[1].valid === 1'b1) mq1.push_back(dmem_req[1]);
		end
	end
	task automatic print_verdict();
		if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	function automatic logic [31:0] ins(input logic c, input logic [2:0] u,
		input logic [2:0] cs, input logic zs, input logic [3:0] d, s1, s2,
		input logic x, input logic [3:0] op, input logic [6:0] hi);
		return {hi, op, x, s2, s1, d, zs, cs, u, c};
	endfunction
	function automatic logic [7:0] mask(input vfd_rec_type r);
		logic [7:0] m;
		for (int i = 0; i < 8; i++) m[i] = r.u[i].valid;
		return m;
	endfunction
	// Expected unit masks of one fetch packet
	task automatic split(input logic [255:0] pk);
		logic [31:0] w;
		logic [7:0]  m;
		int          last;
		m = 8'h00;
		last = 0;
		for (int i = 0; i < 8; i++) if (pk[32*i+:32] !== 32'h00000080) last = i;
		for (int i = 0; i <= last; i++) begin
			w = pk[32*i+:32];
			if (w[7:4] != 4'h8) m[w[3:1]] = 1'b1;
			if (!w[0] || i == last) begin
				eq.push_back(m);
				m = 8'h00;
			end
		end
	endtask
	task automatic start(input logic [3:0] fl, input logic [3:0] dl);
		@(posedge ref_clk);
		#1 rst = 1'b1;
		flat = fl;
		dlat = dl;
		rq.delete(); kq.delete(); cq.delete(); aq.delete(); mq0.delete(); mq1.delete();
		acks = 0;
	endtask
	task automatic go(input int n);
		int i;
		repeat (3) @(posedge ref_clk);
		#1 rst = 1'b0;
		i = 0;
		while (rq.size() < n && i < 2000) begin
			@(posedge ref_clk);
			i++;
		end
		if (rq.size() < n) begin
			bad_count++;
			$display("CHECK FAILED issue count expected %0d seen %0d", n, rq.size());
			print_verdict();
		end
	endtask
	// Chaining, packet counts and fetch order
	task automatic s_chain(input logic [3:0] fl);
		logic [255:0] pk [0:2];
		start(fl, 4'h0);
		pk[0] = {32'h00000080, ins(0, 4, 0, 0, 1, 0, 0, 0, 0, 0), ins(0, 6, 0, 0, 1, 0, 0, 0, 0, 0),
			ins(1, 5, 0, 0, 1, 0, 0, 0, 0, 0), ins(1, 4, 0, 0, 1, 0, 0, 0, 0, 0),
			ins(1, 2, 0, 0, 1, 0, 0, 0, 0, 0), ins(1, 1, 0, 0, 1, 0, 0, 0, 0, 0),
			ins(0, 0, 0, 0, 1, 0, 0, 0, 0, 0)};
		for (int i = 0; i < 8; i++) begin
			pk[1][32*i+:32] = ins(i != 7, i, 0, 0, 1, 0, (i % 4 == 3) ? 4'hA : 4'h0, 0, 0, 0);
			pk[2][32*i+:32] = ins(0, 0, 0, 0, 1, 0, 0, 0, 0, 0);
		end
		eq.delete();
		fp.delete();
		for (int k = 0; k < 3; k++) begin
			u_vfd_mem_model.prog[k] = pk[k];
			split(pk[k]);
			while (fp.size() < eq.size()) fp.push_back(k + 1);
		end
		go(eq.size());
		for (int i = 0; i < eq.size(); i++) begin
			check("unit mask", mask(rq[i]), eq[i]);
			check("fetch count", kq[i], fp[i]);
			check("conflict", rq[i].cf, 1'b0);
			if (i > 0 && fp[i] == fp[i-1]) check("spacing", cq[i] - cq[i-1], 1);
		end
		for (int k = 0; k < 3; k++) check("fetch addr", aq[k], 32 * k);
	endtask
	// Loads, cross path, conditions and unit results
	task automatic s_exec();
		logic [31:0] a2;
		logic [31:0] a3;
		logic [31:0] b2;
		logic [31:0] b3;
		a2 = 32'h00000019;
		a3 = 32'h0000030B;
		b2 = 32'h00000021;
		b3 = 32'h00000313;
		start(4'h1, 4'h2);
		u_vfd_mem_model.prog[0] = {ins(0, 0, 0, 0, 7, 2, 2, 0, 0, 0), ins(1, 0, 2, 0, 6, 2, 3, 0, 1, 0),
			ins(0, 3, 0, 0, 4, 0, 4'hA, 0, 4'h6, 0), ins(1, 2, 0, 0, 5, 2, 3, 0, 0, 0),
			ins(1, 4, 0, 0, 4, 2, 3, 1, 0, 0), ins(1, 0, 0, 0, 4, 2, 3, 0, 0, 0),
			ins(0, 5, 0, 0, 2, 0, 0, 0, 5, 2), ins(0, 1, 0, 0, 2, 0, 0, 0, 5, 1)};
		u_vfd_mem_model.prog[1] = {{5{32'h00000080}}, ins(0, 0, 0, 0, 8, 2, 3, 0, 9, 0),
			ins(1, 6, 6, 0, 5, 2, 3, 0, 0, 0), ins(1, 2, 1, 0, 5, 2, 3, 0, 0, 0)};
		go(5);
		check("load_double_word a", {mask(rq[0]), rq[0].u[1].opc, rq[0].u[1].result},
			{8'h02, `VFD_OP_LOAD_DW, 32'h00000008});
		check("load_double_word b", {mask(rq[1]), rq[1].u[5].result}, {8'h20, 32'h00000010});
		check("mask 2", mask(rq[2]), 8'h1D);
		check("add a", rq[2].u[0].result, a2 + a3);
		check("cross add", rq[2].u[4].result, b2 + a3);
		check("mpy a", rq[2].u[2].result, $signed(a2[15:0]) * $signed(a3[15:0]));
		check("store addr", rq[2].u[3].result, 32'h0000000C);
		check("dual unit", {mask(rq[3]), rq[3].cf, rq[3].u[0].result},
			{8'h01, 1'b1, a2 - a3});
		check("cond mask", mask(rq[4]), 8'h41);
		check("fneg a", rq[4].u[0].result, {~a2[31], a2[30:0]});
		check("mpy b", rq[4].u[6].result, $signed(b2[15:0]) * $signed(b3[15:0]));
		check("dmem a0", {mq0[0].store, mq0[0].size, mq0[0].addr}, {3'h3, 32'h8});
		check("dmem a1", {mq0[1].store, mq0[1].size, mq0[1].be, mq0[1].addr},
			{3'h6, 8'hF0, 32'hC});
		check("dmem b0", {mq1[0].store, mq1[0].size, mq1[0].addr}, {3'h3, 32'h10});
	endtask
	initial begin
		s_chain(4'h0);
		s_chain(4'h3);
		s_exec();
		print_verdict();
	end
endmodule
